/* File: design/sms_defs.svh */
// Constants for the serial master/slave port: clock-divider half periods and reset values.
// Assumes inclusion by the port design files only; holds definitions and nothing else.
`ifndef SMS_DEFS_SVH
`define SMS_DEFS_SVH

// Half period of the link clock, in system clock cycles, per rate selection (normal speed).
`define SMS_HALF_RATE0   7'h02
`define SMS_HALF_RATE1   7'h08
`define SMS_HALF_RATE2   7'h20
`define SMS_HALF_RATE3   7'h40
// Rate selection codes.
`define SMS_RATE_CODE0   2'h0
`define SMS_RATE_CODE1   2'h1
`define SMS_RATE_CODE2   2'h2
`define SMS_RATE_CODE3   2'h3
// Reset values.
`define SMS_RST_BYTE     8'h00
`define SMS_RST_HALF     7'h00
// SCK presets to its idle low level so no false edge follows reset; the other pins preset high.
`define SMS_RST_SYNC     4'h7

`endif

/* File: design/sms_pkg.sv */
// Types shared by the serial master/slave port and its receive buffer.
// Assumes a single system clock; constants live in sms_defs.svh.
package sms_pkg;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'h0,
		ST_LOW  = 2'h1,
		ST_HIGH = 2'h3
	} sms_state_t;

	typedef struct packed
	{
		logic       portEnable;
		logic       masterSelect;
		logic       lsbFirst;
		logic       doubleSpeed;
		logic [1:0] rateSel;
		logic       irqEnable;
	} sms_cfg_t;

	typedef struct packed
	{
		logic mosiOe;
		logic sckOe;
		logic misoOe;
	} sms_dir_t;

	typedef struct packed
	{
		logic transferDone;
		logic writeCollision;
		logic overrun;
		logic busy;
	} sms_status_t;

	typedef struct packed
	{
		logic clrDone;
		logic clrCollision;
		logic clrOverrun;
	} sms_clr_t;

endpackage

/* File: design/sms_rx_buf.sv */
// Small in-order buffer for received bytes; the head entry always sits in slot zero.
// Assumes one clock domain; outputs come straight from registers.
`timescale 1ns/1ps
module sms_rx_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input  wire logic             clk,
	input  wire logic             clkEn,
	input  wire logic             sys_rst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	import sms_pkg::*;

	initial
	begin
		if (WIDTH < 1 || DEPTH < 2)
			$error("sms_rx_buf needs WIDTH >= 1 and DEPTH >= 2");
	end

	logic [DEPTH-1:0] vld_ff;
	logic [WIDTH-1:0] slot_ff [DEPTH];
	logic [DEPTH-1:0] nxt_vld;
	logic [WIDTH-1:0] nxt_slot [DEPTH];
	wire              push = inValid && inReady;
	wire              pop  = vld_ff[0] && outReady;

	assign inReady  = !vld_ff[DEPTH-1];
	assign outValid = vld_ff[0];
	assign outData  = slot_ff[0];

	// Entries move down one slot on every pop, so a push lands in the first slot left empty.
	for (genvar i = 0; i < DEPTH; i++)
	begin : g_slot
		wire             upVld;
		wire [WIDTH-1:0] upData;
		wire             prevVld;
		wire             takePush;
		if (i == DEPTH - 1)
		begin : g_top
			assign upVld  = 1'b0;
			assign upData = slot_ff[i];
		end
		else
		begin : g_mid
			assign upVld  = vld_ff[i+1];
			assign upData = slot_ff[i+1];
		end
		if (i == 0)
		begin : g_first
			assign prevVld = 1'b1;
		end
		else
		begin : g_rest
			assign prevVld = vld_ff[i-1];
		end
		assign takePush   = push && (pop ? (vld_ff[i] && !upVld) : (!vld_ff[i] && prevVld));
		assign nxt_vld[i]  = pop ? (upVld || takePush) : (vld_ff[i] || takePush);
		assign nxt_slot[i] = takePush ? inData : (pop ? upData : slot_ff[i]);

		always_ff @(posedge clk or posedge sys_rst)
		begin
			if (sys_rst)
			begin
				vld_ff[i]  <= 1'b0;
				slot_ff[i] <= '0;
			end
			else if (clkEn)
			begin
				vld_ff[i]  <= nxt_vld[i];
				slot_ff[i] <= nxt_slot[i];
			end
		end
	end

endmodule // sms_rx_buf

/* File: design/sms_port.sv */
// Byte-oriented serial port that runs as link master or slave over SCK, MOSI, MISO and slave select.
// Assumes pin inputs arrive asynchronously and software drives the control ports on clk.
// Notes on behaviour
// R1: Master pulls slave select low before clocking.
// R2: Bytes swap over MOSI and MISO together.
// R3: Master raises slave select after each packet.
// R4: Master never drives slave select itself.
// R5: Master write starts clock, shifts eight bits.
// R6: Master stops clock, sets done after byte.
// R7: Done with enable bit requests an interrupt.
// R8: Master sends further bytes by further writes.
// R9: Last received byte stays readable afterwards.
// R10: Idle slave ignores SCK, floats MISO.
// R11: Idle slave accepts writes, shifts them later.
// R12: Slave sets done after a full byte.
// R13: Slave may reload transmit before reading receive.
// R14: Transmit single buffered, write only when idle.
// R15: Unread received byte is overwritten next byte.
// R16: External SCK stays at quarter clock or less.
// R17: Enabled port forces pin directions per mode; the code forces only the input pins, output enables follow userDir.
// R18: Master or slave chosen by control bit.
// R19: Bit order selectable, LSB or MSB first.
// R20: Rate bit zero alone gives clock over sixteen.
// R21: Double speed master gives clock over two.
// R22: Write during transfer sets collision flag.
`timescale 1ns/1ps
`include "sms_defs.svh"
module sms_port #(
	parameter int DATA_W    = 8,
	parameter int BUF_DEPTH = 2
) (
	input  wire logic                clk,
	input  wire logic                clkEn,
	input  wire logic                sys_rst,
	input  wire sms_pkg::sms_cfg_t   cfg,
	input  wire sms_pkg::sms_dir_t   userDir,
	input  wire logic                wrStrobe,
	input  wire logic [DATA_W-1:0]   wrData,
	input  wire logic                rxRead,
	input  wire sms_pkg::sms_clr_t   flagClr,
	output sms_pkg::sms_status_t     status,
	output logic                     irqReq,
	output logic      [DATA_W-1:0]   rxByte,
	output logic                     rxStreamValid,
	input  wire logic                rxStreamReady,
	output logic      [DATA_W-1:0]   rxStreamData,
	input  wire logic                sckIn,
	output logic                     sckOut,
	output logic                     sckOe,
	input  wire logic                mosiIn,
	output logic                     mosiOut,
	output logic                     mosiOe,
	input  wire logic                misoIn,
	output logic                     misoOut,
	output logic                     misoOe,
	input  wire logic                ssIn_n
);
	import sms_pkg::*;

	localparam int CNT_W = $clog2(DATA_W);

	initial
	begin
		if (DATA_W < 2 || BUF_DEPTH < 2)
			$error("sms_port needs DATA_W >= 2 and BUF_DEPTH >= 2");
	end

	function automatic logic [6:0] halfPeriod(input logic [1:0] rate, input logic dbl);
		logic [6:0] half;
		half = `SMS_HALF_RATE0;
		unique case (rate)
			`SMS_RATE_CODE0: half = `SMS_HALF_RATE0;
			`SMS_RATE_CODE1: half = `SMS_HALF_RATE1;
			`SMS_RATE_CODE2: half = `SMS_HALF_RATE2;
			`SMS_RATE_CODE3: half = `SMS_HALF_RATE3;
		endcase
		return dbl ? (half >> 1) : half;
	endfunction

	function automatic logic txBitOf(input logic [DATA_W-1:0] sh, input logic lsb);
		return lsb ? sh[0] : sh[DATA_W-1];
	endfunction

	// Pin synchronisers: bit 3 SCK, bit 2 MOSI, bit 1 MISO, bit 0 slave select.
	logic [3:0]        syncA_ff;
	logic [3:0]        syncB_ff;
	logic              prevSck_ff;
	sms_state_t        state_ff;
	sms_state_t        nxt_state;
	logic [6:0]        halfCnt_ff;
	logic [6:0]        nxt_halfCnt;
	logic [CNT_W-1:0]  bitCnt_ff;
	logic              midBit_ff;
	logic              inBit_ff;
	logic              startPend_ff;
	logic [DATA_W-1:0] shift_ff;
	logic              rxUnread_ff;
	sms_status_t       status_ff;
	logic              irqReq_ff;
	logic [DATA_W-1:0] rxByte_ff;
	logic              sckOut_ff;
	logic              txOut_ff;
	sms_dir_t          oe_ff;
	sms_dir_t          nxt_oe;
	logic              bufInReady;

	wire              sckS      = syncB_ff[3];
	wire              mosiS     = syncB_ff[2];
	wire              misoS     = syncB_ff[1];
	wire              ssActive  = !syncB_ff[0];
	wire              isMaster  = cfg.portEnable && cfg.masterSelect;                        // R18
	wire              isSlave   = cfg.portEnable && !cfg.masterSelect;                       // R18
	wire [6:0]        halfTop   = halfPeriod(cfg.rateSel, cfg.doubleSpeed);                  // R20 R21
	wire              mstRise   = state_ff == ST_LOW && halfCnt_ff == `SMS_RST_HALF;
	wire              mstFall   = state_ff == ST_HIGH && halfCnt_ff == `SMS_RST_HALF;
	// The slave only reacts to SCK edges while selected; the quarter-rate limit keeps each edge visible.
	wire              slvRise   = isSlave && ssActive && sckS && !prevSck_ff;                // R10 R16
	wire              slvFall   = isSlave && ssActive && !sckS && prevSck_ff;                // R10 R16
	wire              sampleEv  = isMaster ? mstRise : slvRise;                              // R2
	wire              shiftEv   = isMaster ? mstFall : slvFall;                              // R2
	wire              sampleBit = isMaster ? misoS : mosiS;                                  // R2
	wire              lastBit   = bitCnt_ff == CNT_W'(DATA_W - 1);
	wire              byteDone  = shiftEv && lastBit;                                        // R6 R12
	wire              busy      = isMaster ? (state_ff != ST_IDLE || startPend_ff)
	                                       : (bitCnt_ff != '0 || midBit_ff);
	wire              wrAccept  = wrStrobe && cfg.portEnable && !busy;                       // R11 R13 R14
	wire              wrCollide = wrStrobe && cfg.portEnable && busy;                        // R22
	wire              mstStart  = isMaster && state_ff == ST_IDLE && startPend_ff && bufInReady;
	wire [DATA_W-1:0] shifted   = cfg.lsbFirst ? {inBit_ff, shift_ff[DATA_W-1:1]}            // R19
	                                           : {shift_ff[DATA_W-2:0], inBit_ff};
	wire [DATA_W-1:0] nxt_shift = wrAccept ? wrData : (shiftEv ? shifted : shift_ff);
	wire              nxt_tx    = txBitOf(nxt_shift, cfg.lsbFirst);                          // R19
	wire              rxPush    = byteDone;
	wire              rxDrop    = byteDone && !bufInReady;
	wire              lostByte  = byteDone && rxUnread_ff && !rxRead;                        // R15
	wire              nxt_done  = (status_ff.transferDone && !flagClr.clrDone) || byteDone;
	wire              nxt_coll  = (status_ff.writeCollision && !flagClr.clrCollision) || wrCollide;
	wire              nxt_ovr   = (status_ff.overrun && !flagClr.clrOverrun) || lostByte || rxDrop;

	// Master clock generator: an idle state and two half-period states that each last halfTop cycles.
	always_comb
	begin
		nxt_state   = state_ff;
		nxt_halfCnt = halfCnt_ff;
		if (!isMaster)
		begin
			nxt_state   = ST_IDLE;
			nxt_halfCnt = `SMS_RST_HALF;
		end
		else
		begin
			unique case (state_ff)
				ST_IDLE:
				begin
					if (mstStart)
					begin
						nxt_state   = ST_LOW;                                                // R5
						nxt_halfCnt = halfTop - 7'h01;
					end
				end
				ST_LOW:
				begin
					if (mstRise)
					begin
						nxt_state   = ST_HIGH;
						nxt_halfCnt = halfTop - 7'h01;
					end
					else
						nxt_halfCnt = halfCnt_ff - 7'h01;
				end
				ST_HIGH:
				begin
					if (mstFall)
					begin
						nxt_state   = lastBit ? ST_IDLE : ST_LOW;                            // R6
						nxt_halfCnt = halfTop - 7'h01;
					end
					else
						nxt_halfCnt = halfCnt_ff - 7'h01;
				end
				default:
				begin
					nxt_state   = ST_IDLE;
					nxt_halfCnt = `SMS_RST_HALF;
				end
			endcase
		end
	end

	// Pin directions. Slave select is never driven here; software owns it in master mode.
	always_comb
	begin
		nxt_oe = '0;
		if (isMaster)
		begin
			nxt_oe.mosiOe = userDir.mosiOe;                                                  // R17 R4
			nxt_oe.sckOe  = userDir.sckOe;                                                   // R17
		end
		else if (isSlave)
			nxt_oe.misoOe = userDir.misoOe && ssActive;                                      // R17 R10
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			syncA_ff   <= `SMS_RST_SYNC;
			syncB_ff   <= `SMS_RST_SYNC;
			prevSck_ff <= 1'b0;
		end
		else if (clkEn)
		begin
			syncA_ff   <= {sckIn, mosiIn, misoIn, ssIn_n};
			syncB_ff   <= syncA_ff;
			prevSck_ff <= sckS;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_ff     <= ST_IDLE;
			halfCnt_ff   <= `SMS_RST_HALF;
			startPend_ff <= 1'b0;
		end
		else if (clkEn)
		begin
			state_ff     <= nxt_state;
			halfCnt_ff   <= nxt_halfCnt;
			// A master write waits here while the receive buffer is full, so no byte is lost.
			startPend_ff <= isMaster && ((startPend_ff && !mstStart) || wrAccept);           // R5 R8
		end
	end

	// Bit engine. A slave deselected mid-byte drops the partial byte and starts again cleanly.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			bitCnt_ff <= '0;
			midBit_ff <= 1'b0;
			inBit_ff  <= 1'b0;
			shift_ff  <= `SMS_RST_BYTE;
			txOut_ff  <= 1'b0;
		end
		else if (clkEn)
		begin
			if (!cfg.portEnable || (isSlave && !ssActive))
			begin
				bitCnt_ff <= '0;                                                             // R10 R3
				midBit_ff <= 1'b0;
			end
			else if (shiftEv)
			begin
				bitCnt_ff <= lastBit ? '0 : bitCnt_ff + CNT_W'(1);                           // R5 R12
				midBit_ff <= 1'b0;
			end
			else if (sampleEv)
				midBit_ff <= 1'b1;
			if (sampleEv)
				inBit_ff <= sampleBit;                                                       // R2
			shift_ff <= nxt_shift;                                                           // R11 R14
			txOut_ff <= nxt_tx;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rxByte_ff   <= `SMS_RST_BYTE;
			rxUnread_ff <= 1'b0;
			status_ff   <= '0;
			irqReq_ff   <= 1'b0;
		end
		else if (clkEn)
		begin
			if (byteDone)
				rxByte_ff <= shifted;                                                        // R9 R15
			rxUnread_ff <= byteDone || (rxUnread_ff && !rxRead);
			status_ff   <= '{transferDone: nxt_done, writeCollision: nxt_coll,
			                 overrun: nxt_ovr, busy: busy};                                  // R6 R12 R22
			irqReq_ff   <= nxt_done && cfg.irqEnable;                                        // R7
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sckOut_ff <= 1'b0;
			oe_ff     <= '0;
		end
		else if (clkEn)
		begin
			sckOut_ff <= nxt_state == ST_HIGH;                                               // R5
			oe_ff     <= nxt_oe;
		end
	end

	sms_rx_buf #(
		.WIDTH (DATA_W),
		.DEPTH (BUF_DEPTH)
	) u_rx_buf (
		.clk      (clk),
		.clkEn    (clkEn),
		.sys_rst  (sys_rst),
		.inValid  (rxPush),
		.inReady  (bufInReady),
		.inData   (shifted),
		.outValid (rxStreamValid),
		.outReady (rxStreamReady),
		.outData  (rxStreamData)
	);

	assign status  = status_ff;
	assign irqReq  = irqReq_ff;
	assign rxByte  = rxByte_ff;
	assign sckOut  = sckOut_ff;
	assign sckOe   = oe_ff.sckOe;
	assign mosiOut = txOut_ff;
	assign mosiOe  = oe_ff.mosiOe;
	assign misoOut = txOut_ff;
	assign misoOe  = oe_ff.misoOe;

	property p_start;
		@(posedge clk) disable iff (sys_rst)
		clkEn && mstStart |=> state_ff == ST_LOW && startPend_ff == 1'b0;
	endproperty
	a_start: assert property (p_start) else $error("master did not start the clock"); // R5

	property p_done_set;
		@(posedge clk) disable iff (sys_rst)
		clkEn && byteDone |=> status.transferDone && rxByte == $past(shifted);
	endproperty
	a_done_set: assert property (p_done_set) else $error("byte end not flagged"); // R6

	property p_master_stop;
		@(posedge clk) disable iff (sys_rst)
		clkEn && isMaster && byteDone |=> state_ff == ST_IDLE ##1 !sckOut;
	endproperty
	a_master_stop: assert property (p_master_stop) else $error("clock kept running after byte"); // R6

	property p_irq;
		@(posedge clk) disable iff (sys_rst)
		clkEn && byteDone && cfg.irqEnable |=> irqReq;
	endproperty
	a_irq: assert property (p_irq) else $error("no interrupt request on byte end"); // R7

	property p_slave_idle;
		@(posedge clk) disable iff (sys_rst)
		clkEn && isSlave && !ssActive |=> !misoOe && bitCnt_ff == '0;
	endproperty
	a_slave_idle: assert property (p_slave_idle) else $error("deselected slave not idle"); // R10

	property p_idle_write;
		@(posedge clk) disable iff (sys_rst)
		clkEn && isSlave && !ssActive && wrStrobe |=> shift_ff == $past(wrData) && !status.writeCollision;
	endproperty
	a_idle_write: assert property (p_idle_write) else $error("idle slave refused a write"); // R11

	property p_collision;
		@(posedge clk) disable iff (sys_rst)
		clkEn && wrCollide |=> status.writeCollision && (shift_ff == $past(shift_ff) || $past(shiftEv));
	endproperty
	a_collision: assert property (p_collision) else $error("collision not flagged or write taken"); // R22 R14

	property p_overrun;
		@(posedge clk) disable iff (sys_rst)
		clkEn && lostByte |=> status.overrun;
	endproperty
	a_overrun: assert property (p_overrun) else $error("lost byte not flagged"); // R15

	property p_rate16;
		@(posedge clk) disable iff (sys_rst)
		cfg.rateSel == `SMS_RATE_CODE1 && !cfg.doubleSpeed |-> halfTop == 7'h08;
	endproperty
	a_rate16: assert property (p_rate16) else $error("rate one is not clock over sixteen"); // R20

	property p_double;
		@(posedge clk) disable iff (sys_rst)
		clkEn && isMaster && cfg.doubleSpeed && cfg.rateSel == `SMS_RATE_CODE0 && mstRise
		##1 clkEn |-> sckOut ##1 !sckOut;
	endproperty
	a_double: assert property (p_double) else $error("double speed high phase too long"); // R21

	property p_dirs;
		@(posedge clk) disable iff (sys_rst)
		clkEn && isMaster |=> !misoOe;
	endproperty
	a_dirs: assert property (p_dirs) else $error("master drove its data input"); // R17

endmodule // sms_port

/* File: dv/sms_peer.sv */
// Far-side link model: a mode-0 slave while the port masters, a master driven by run() while it listens.
// Assumes the bench drives the select line and calls run() at falling clock edges.
`timescale 1ns/1ps
module sms_peer (
	input  wire logic       clk,
	input  wire logic       slaveRole,
	input  wire logic       selN,
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       miso,
	output logic            peerMiso,
	output logic            peerSck,
	output logic            peerMosi,
	output logic [7:0]      peerRx,
	output logic [7:0]      peerTx
);
	initial
	begin
		peerSck  = 1'h0;
		peerMosi = 1'h0;
		peerRx   = 8'h00;
		peerTx   = 8'h00;
	end
	// A released line shows the inverted bit, so a stale level never passes for data.
	assign peerMiso = (selN || !slaveRole) ? ~peerTx[7] : peerTx[7];
	always @(posedge sck)
		if (slaveRole && !selN)
			peerRx <= {peerRx[6:0], mosi};
	always @(negedge sck)
		if (slaveRole && !selN)
			peerTx <= {peerTx[6:0], peerTx[7]};
	task automatic load(input logic [7:0] b);
		peerTx = b;
	endtask
	// Each phase lasts half clock periods; half must stay at 2 or more for the port to sample it.
	task automatic run(input logic [7:0] tx, input int half);
		peerMosi = tx[7];
		for (int i = 0; i < 8; i++)
		begin
			repeat (half) @(negedge clk);
			peerSck = 1'h1;
			peerRx  = {peerRx[6:0], miso};
			repeat (half) @(negedge clk);
			peerSck  = 1'h0;
			tx       = {tx[6:0], 1'h0};
			peerMosi = (i == 7) ? ~peerMosi : tx[7];
		end
	endtask
endmodule // sms_peer

/* File: dv/tb_sms_port.sv */
// Self-checking bench: runs the serial port as link master and as link slave against the peer model.
// Assumes sms_peer is compiled first; the clock enable is tied high since no scenario freezes the port.
`timescale 1ns/1ps
module tb_sms_port;
	import sms_pkg::*;
	logic        clk;
	logic        sysRst;
	sms_cfg_t    cfg;
	sms_dir_t    userDir;
	logic        wrStrobe;
	logic [7:0]  wrData;
	logic        rxRead;
	sms_clr_t    flagClr;
	sms_status_t status;
	logic        irqReq;
	logic [7:0]  rxByte;
	logic        rxStreamValid;
	logic        rxStreamReady;
	logic [7:0]  rxStreamData;
	logic        sckOut;
	logic        sckOe;
	logic        mosiOut;
	logic        mosiOe;
	logic        misoOut;
	logic        misoOe;
	logic        ssN;
	logic        peerMiso;
	logic        peerSck;
	logic        peerMosi;
	logic [7:0]  peerRx;
	int          mismatches;
	int          cmp_count;
	int          halfTab [4] = '{2, 8, 32, 64};
	// The SCK, MOSI and MISO lines resolve from the enables, so a wrong direction shows up as corrupt data.
	wire         sckW  = sckOe ? sckOut : peerSck;
	wire         mosiW = mosiOe ? mosiOut : peerMosi;
	wire         misoW = misoOe ? misoOut : peerMiso;
	wire         ssDut = cfg.masterSelect | ssN;

	sms_port u_dut (.clk(clk), .clkEn(1'h1), .sys_rst(sysRst), .cfg(cfg), .userDir(userDir), .wrStrobe(wrStrobe),
		.wrData(wrData), .rxRead(rxRead), .flagClr(flagClr), .status(status), .irqReq(irqReq), .rxByte(rxByte),
		.rxStreamValid(rxStreamValid), .rxStreamReady(rxStreamReady), .rxStreamData(rxStreamData), .sckIn(sckW),
		.sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiW), .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoW),
		.misoOut(misoOut), .misoOe(misoOe), .ssIn_n(ssDut));
	sms_peer u_peer (.clk(clk), .slaveRole(cfg.masterSelect), .selN(ssN), .sck(sckW), .mosi(mosiW), .miso(misoW),
		.peerMiso(peerMiso), .peerSck(peerSck), .peerMosi(peerMosi), .peerRx(peerRx), .peerTx());

	always #5 clk = ~clk;

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	function automatic logic [7:0] rev8(input logic [7:0] b);
		for (int i = 0; i < 8; i++)
			rev8[i] = b[7 - i];
	endfunction
	task automatic wr(input logic [7:0] b);
		@(negedge clk);
		wrStrobe = 1'h1;
		wrData   = b;
		@(negedge clk);
		wrStrobe = 1'h0;
	endtask
	task automatic clr(input sms_clr_t c);
		@(negedge clk);
		flagClr = c;
		@(negedge clk);
		flagClr = '0;
	endtask
	task automatic readRx();
		rxRead = 1'h1;
		@(negedge clk);
		rxRead = 1'h0;
	endtask
	task automatic waitDone();
		int n;
		n = 0;
		while (status.transferDone !== 1'h1)
		begin
			@(negedge clk);
			n++;
			if (n > 3000)
			begin
				chk(8'h00, 8'h01, "timeout");
				summarize();
			end
		end
		@(negedge clk);
	endtask
	task automatic waitSck(input logic lvl, output int n);
		n = 0;
		while (sckOut !== lvl && n < 300)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 300)
		begin
			chk(8'h00, 8'h01, "sck timeout");
			summarize();
		end
	endtask
	task automatic setCfg(input logic m, input logic l, input logic d, input logic [1:0] r, input logic ie);
		@(negedge clk);
		cfg = {1'h1, m, l, d, r, ie};
		repeat (4) @(negedge clk);
	endtask
	// The port is a slave here; the peer clocks at one sixteenth of the system clock.
	task automatic frame(input logic [7:0] b);
		ssN = 1'h0;
		repeat (4) @(negedge clk);
		u_peer.run(b, 8);
		waitDone();
		ssN = 1'h1;
	endtask

	task automatic t_master(input logic l, input logic ie);
		setCfg(1'h1, l, 1'h0, 2'h1, ie);
		u_peer.load(8'hA6);
		ssN = 1'h0;
		wr(8'hB4);
		waitDone();
		chk(peerRx, l ? rev8(8'hB4) : 8'hB4, "mosi byte");
		chk(rxByte, l ? rev8(8'hA6) : 8'hA6, "miso byte");
		chk(irqReq, ie, "irq");
		chk(misoOe, 1'h0, "miso dir");
		repeat (20) @(negedge clk);
		chk({sckOut, status.busy}, 8'h00, "clock stopped");
		ssN = 1'h1;
		clr(3'h7);
		chk(irqReq, 1'h0, "irq cleared");
		$display("test master done");
	endtask

	task automatic t_collide();
		setCfg(1'h1, 1'h0, 1'h0, 2'h1, 1'h0);
		ssN = 1'h0;
		wr(8'h5A);
		wr(8'hFF);
		chk(status.writeCollision, 1'h1, "collision");
		waitDone();
		chk(peerRx, 8'h5A, "first byte kept");
		clr(3'h7);
		wr(8'hC3);
		waitDone();
		chk(peerRx, 8'hC3, "next byte");
		clr(3'h7);
		ssN = 1'h1;
		$display("test collide done");
	endtask

	task automatic t_rates();
		int n;
		ssN = 1'h0;
		for (int r = 0; r < 4; r++)
			for (int d = 0; d < 2; d++)
			begin
				setCfg(1'h1, 1'h0, d[0], r[1:0], 1'h0);
				wr(8'h81);
				waitSck(1'h1, n);
				waitSck(1'h0, n);
				chk(8'(n), 8'(halfTab[r] >> d), "sck half period");
				waitDone();
				clr(3'h7);
			end
		ssN = 1'h1;
		$display("test rates done");
	endtask

	task automatic t_slave();
		setCfg(1'h0, 1'h0, 1'h0, 2'h0, 1'h1);
		wr(8'h96);
		u_peer.run(8'hFF, 8);
		repeat (6) @(negedge clk);
		chk(status.transferDone, 1'h0, "deselected");
		chk(misoOe, 1'h0, "miso released");
		chk({sckOe, mosiOe}, 8'h00, "slave dirs");
		frame(8'h69);
		chk(peerRx, 8'h96, "slave tx");
		chk(rxByte, 8'h69, "slave rx");
		chk(irqReq, 1'h1, "slave irq");
		wr(8'h0F);
		chk(rxByte, 8'h69, "rx kept");
		clr(3'h7);
		$display("test slave done");
	endtask

	// The receiver stalls while three bytes arrive, so the two-entry buffer fills and drops one.
	task automatic t_overrun();
		rxStreamReady = 1'h1;
		readRx();
		repeat (3) @(negedge clk);
		rxStreamReady = 1'h0;
		clr(3'h7);
		for (int i = 1; i < 4; i++)
		begin
			frame(8'(i * 17));
			clr(3'h4);
		end
		chk(status.overrun, 1'h1, "overrun");
		chk(rxByte, 8'h33, "latest byte");
		for (int i = 1; i < 3; i++)
		begin
			chk(rxStreamValid, 1'h1, "stream valid");
			chk(rxStreamData, 8'(i * 17), "stream order");
			rxStreamReady = 1'h1;
			@(negedge clk);
			rxStreamReady = 1'h0;
			@(negedge clk);
		end
		chk(rxStreamValid, 1'h0, "stream empty");
		readRx();
		clr(3'h7);
		frame(8'h44);
		chk(status.overrun, 1'h0, "no overrun");
		$display("test overrun done");
	endtask

	initial
	begin
		clk           = 1'h0;
		sysRst        = 1'h1;
		cfg           = '0;
		userDir       = 3'h7;
		wrStrobe      = 1'h0;
		wrData        = 8'h00;
		rxRead        = 1'h0;
		flagClr       = '0;
		// The stream drains freely so a full buffer never stalls a master start.
		rxStreamReady = 1'h1;
		ssN           = 1'h1;
		mismatches    = 0;
		cmp_count     = 0;
		repeat (5) @(negedge clk);
		sysRst = 1'h0;
		chk({4'h0, status}, 8'h00, "reset status");
		chk(rxByte, 8'h00, "reset rx");
		t_master(1'h0, 1'h1);
		t_master(1'h1, 1'h0);
		t_collide();
		t_rates();
		t_slave();
		t_overrun();
		summarize();
	end
endmodule // tb_sms_port
